// *** test_voice_converter_sample_timing.sv ***
// self-checking bench for the sample timing block
`default_nettype none
module test_voice_converter_sample_timing;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rstn, xtal_clk, dac_rate_sel, dac_valid, dac_ready;
  logic adc_valid, pwm_out, dac_tick, adc_tick;
  vcst_pkg::vcst_duty_t dac_sample;
  vcst_pkg::vcst_adc_t  adc_code, adc_sample;
  int failures, checks_done;
  vcst_top u_dut (.clk, .rstn, .xtal_clk, .dac_rate_sel, .dac_sample, .dac_valid,
    .dac_ready, .adc_code, .adc_sample, .adc_valid, .pwm_out, .dac_tick, .adc_tick);
  vcst_dsp_model u_dsp (.clk, .dac_ready, .dac_sample, .dac_valid);
  // 48 ns crystal keeps whole clock counts: 1280 edges are 7680 clocks
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    xtal_clk = 1'b0;
    forever #24 xtal_clk = ~xtal_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  function automatic bit near(int a, int e, int t);
    return a >= e - t && a <= e + t;
  endfunction : near
  // one period from tick to tick; sync of the crystal pin gives a clock of jitter
  task automatic period(input bit dac, output int n, output int hi);
    int k;
    n = 0;
    hi = 0;
    for (k = 0; k < 20000 && !(dac ? dac_tick : adc_tick); k++) @(negedge clk);
    if (k == 20000) begin
      failures++;
      end_of_test();
    end
    @(negedge clk);
    for (k = 0; k < 20000 && !(dac ? dac_tick : adc_tick); k++) begin
      n++;
      hi += int'(pwm_out === 1'b1);
      @(negedge clk);
    end
    if (k == 20000) begin
      failures++;
      end_of_test();
    end
  endtask : period
  // fill right after a tick until refused, then duties must play in order
  task automatic fill_and_play;
    int n, hi, i;
    bit ok;
    period(1'b1, n, hi);
    @(posedge clk); // offers start just after a rising edge
    for (i = 0; i < 17; i++) begin
      u_dsp.push(10'(1023 - i * 60), i % 2 * 3, ok);
      check(32'(ok), 32'h1);
    end
    u_dsp.push(10'h000, 0, ok);
    check(32'(ok), 32'h0);
    for (i = 0; i < 2; i++) begin
      period(1'b1, n, hi);
      check(32'(near(n, 7679, 1)), 32'h1);
      check(32'(near(hi, 6 * (1023 - i * 60), 8)), 32'h1);
    end
  endtask : fill_and_play
  // two codes in turn must each be held in adc_sample at the second adc tick after they are driven
  task automatic adc_capture;
    int n, hi, i;
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      #1 adc_code = i ? 8'hc3 : 8'h3c;
      period(1'b0, n, hi);
      check(32'(near(n, 7679, 1)), 32'h1);
      check(32'(adc_sample), i ? 32'hc3 : 32'h3c);
      check(32'(adc_valid), 32'h1);
    end
  endtask : adc_capture
  // slower dac rate while the adc stays put; the queue keeps playing in order
  task automatic rate_switch;
    int n, hi;
    @(posedge clk);
    #1 dac_rate_sel = 1'b1;
    period(1'b1, n, hi);
    period(1'b1, n, hi);
    check(32'(near(n, 12287, 1)), 32'h1);
    // adc ticks coincide with dac ticks at 16 kHz, so this is the ninth queued sample
    check(32'(near(hi, 6 * (1023 - 8 * 60), 8)), 32'h1);
  endtask : rate_switch
  initial begin
    rstn = 1'b0;
    dac_rate_sel = 1'b0;
    adc_code = 8'ha5;
    failures = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (2) @(posedge clk);
    fill_and_play();
    adc_capture();
    rate_switch();
    end_of_test();
  end
endmodule : test_voice_converter_sample_timing
`default_nettype wire

// *** vcst_consts.svh ***
// constants for the voice converter sample timing block
// Function
// [R1] pwm output has 1024 duty levels
// [R2] default pwm rate 16 kHz at 20.48 MHz
// [R3] software selects 10 kHz or 16 kHz pwm rate
// [R4] adc gives 8-bit samples at 16 kHz ticks
// [R5] two independent adc and dac rate timers
// [R6] timers free run, tick at each wrap
// [R7] pwm is a single two-level line
// [R8] new duty loaded only at dac tick
`ifndef VCST_CONSTS_SVH
`define VCST_CONSTS_SVH
`define VCST_CLK_HZ        125000000
`define VCST_XTAL_HZ       20480000
`define VCST_RATE_16K_HZ   16000
`define VCST_RATE_10K_HZ   10000
`define VCST_PWM_BITS      10
`define VCST_ADC_BITS      8
`define VCST_FIFO_DEPTH    16
// divisions of the crystal, rounded down to whole cycles
`define VCST_DIV_16K       (`VCST_XTAL_HZ / `VCST_RATE_16K_HZ)
`define VCST_DIV_10K       (`VCST_XTAL_HZ / `VCST_RATE_10K_HZ)
`define VCST_DAC_RATE_RST  1'h0
`endif

// *** vcst_dsp_model.sv ***
// signal processor model offering dac samples over valid/ready
`default_nettype none
module vcst_dsp_model
  import vcst_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      dac_ready,
  output var vcst_duty_t dac_sample,
  output var logic       dac_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    dac_sample = 10'h155;
    dac_valid = 1'b0;
  end
  // offer held until ready is seen at an edge, for at most 20 edges; data scrambled after so stale values show
  task automatic push(input vcst_duty_t v, input int lag, output bit ok);
    int n;
    repeat (lag) @(posedge clk);
    #1 dac_sample = v;
    dac_valid = 1'b1;
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clk);
      ok = (dac_ready === 1'b1);
    end
    #1 dac_valid = 1'b0;
    dac_sample = ~v;
  endtask : push
endmodule : vcst_dsp_model
`default_nettype wire

// *** vcst_fifo.sv ***
// parameterised fifo with valid/ready on both sides
`default_nettype none
module vcst_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic clk,
  input  wire logic rstn,
  vcst_stream_if.snk wr,
  vcst_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      rptr_reg;
  logic [WIDTH-1:0] dout_reg;
  logic             dvalid_reg;
  wire              full  = (wptr_reg[AW] != rptr_reg[AW]) &&
                            (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
  wire              empty = (wptr_reg == rptr_reg);
  wire              push  = wr.valid && !full;
  // output register refills when empty or being taken
  wire              pop   = !empty && (!dvalid_reg || rd.ready);
  assign wr.ready = !full;
  assign rd.data  = dout_reg;
  assign rd.valid = dvalid_reg;
  // storage has no reset, read data leave through a register
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_reg[AW-1:0]] <= wr.data;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr_reg   <= '0;
      rptr_reg   <= '0;
      dout_reg   <= '0;
      dvalid_reg <= 1'b0;
    end else begin
      if (push) wptr_reg <= wptr_reg + 1'b1;
      if (pop) begin
        rptr_reg   <= rptr_reg + 1'b1;
        dout_reg   <= mem[rptr_reg[AW-1:0]];
        dvalid_reg <= 1'b1;
      end else if (rd.ready) begin
        dvalid_reg <= 1'b0;
      end
    end
  end
endmodule : vcst_fifo
`default_nettype wire

// *** vcst_pkg.sv ***
// types shared by the sample timing block
`default_nettype none
package vcst_pkg;
  typedef logic [9:0]  vcst_duty_t;
  typedef logic [7:0]  vcst_adc_t;
  typedef logic [11:0] vcst_div_t;
  typedef enum logic [0:0] {
    VCST_RATE_16K = 1'b0,
    VCST_RATE_10K = 1'b1
  } vcst_rate_e;
endpackage : vcst_pkg
`default_nettype wire

// *** vcst_props.sv ***
// port checker for the sample timing block
`default_nettype none
module vcst_props (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       dac_valid,
  input wire logic       dac_ready,
  input wire logic [7:0] adc_sample,
  input wire logic       adc_valid,
  input wire logic       pwm_out,
  input wire logic       dac_tick,
  input wire logic       adc_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // dividers span thousands of clocks, so a quick retick is a counting slip
  dac_gap_a: assert property (dac_tick |=> !dac_tick [*8]) else $error("dac retick");
  adc_gap_a: assert property (adc_tick |=> !adc_tick [*8]) else $error("adc retick");
  adc_pair_a: assert property (adc_valid == adc_tick) else $error("adc off tick");
  adc_pulse_a: assert property (adc_valid |=> $fell(adc_valid)) else $error("adc long");
  adc_hold_a: assert property (!adc_valid |-> $stable(adc_sample)) else $error("adc moved");
  take_drop_a: assert property (dac_valid && dac_ready |=> !dac_ready)
    else $error("ready held");
  pwm_start_a: assert property ($rose(pwm_out) |-> $past(dac_tick))
    else $error("pwm rise off tick");
  // once the ramp passes the duty the line stays low to the period end
  pwm_fall_a: assert property ($fell(pwm_out) |=> !pwm_out [*8]) else $error("pwm glitch");
  cover property (dac_valid && dac_ready);
  cover property (adc_valid);
  cover property (dac_tick ##2 pwm_out);
endmodule : vcst_props
bind vcst_top vcst_props u_props (.clk, .rstn, .dac_valid, .dac_ready, .adc_sample,
  .adc_valid, .pwm_out, .dac_tick, .adc_tick);
`default_nettype wire

// *** vcst_stream_if.sv ***
// valid/ready stream carrier between the block's modules
`default_nettype none
interface vcst_stream_if #(parameter int WIDTH = 10);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : vcst_stream_if
`default_nettype wire

// *** vcst_top.sv ***
// sample-rate timers, pwm dac output and adc sample capture
`include "vcst_consts.svh"
`default_nettype none
module vcst_top
  import vcst_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       xtal_clk,
  input  wire logic       dac_rate_sel,
  input  wire logic [9:0] dac_sample,
  input  wire logic       dac_valid,
  output logic            dac_ready,
  input  wire logic [7:0] adc_code,
  output logic [7:0]      adc_sample,
  output logic            adc_valid,
  output logic            pwm_out,
  output logic            dac_tick,
  output logic            adc_tick
);
  // crystal arrives as a pin: two flops before any logic looks at it
  logic xtal_s1_reg;
  logic xtal_s2_reg;
  logic xtal_s3_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xtal_s1_reg <= 1'b0;
      xtal_s2_reg <= 1'b0;
      xtal_s3_reg <= 1'b0;
    end else begin
      xtal_s1_reg <= xtal_clk;
      xtal_s2_reg <= xtal_s1_reg;
      xtal_s3_reg <= xtal_s2_reg;
    end
  end
  wire xtal_rise = xtal_s2_reg && !xtal_s3_reg;

  // rate select is a level from software, synchronised too
  logic rate_s1_reg;
  logic rate_s2_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rate_s1_reg <= `VCST_DAC_RATE_RST;
      rate_s2_reg <= `VCST_DAC_RATE_RST;
    end else begin
      rate_s1_reg <= dac_rate_sel;
      rate_s2_reg <= rate_s1_reg;
    end
  end
  wire vcst_rate_e dac_rate = vcst_rate_e'(rate_s2_reg);

  // two independent dividers: index 0 paces the dac, 1 the adc
  localparam vcst_div_t DIV16 = vcst_div_t'(`VCST_DIV_16K);
  localparam vcst_div_t DIV10 = vcst_div_t'(`VCST_DIV_10K);
  wire vcst_div_t div_end [2];
  assign div_end[0] = (dac_rate == VCST_RATE_10K) ? DIV10 - 1'b1 : DIV16 - 1'b1; // R2 R3
  assign div_end[1] = DIV16 - 1'b1;                                             // R4
  logic [1:0] tick_w;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_div // R5
      vcst_div_t cnt_reg;
      wire       wrap = xtal_rise && (cnt_reg >= div_end[g]);
      // free running; >= lets a rate change up to 16 kHz take effect at once
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          cnt_reg <= '0;
        end else if (xtal_rise) begin
          cnt_reg <= wrap ? '0 : cnt_reg + 1'b1; // R6
        end
      end
      assign tick_w[g] = wrap; // R6
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dac_tick <= 1'b0;
      adc_tick <= 1'b0;
    end else begin
      dac_tick <= tick_w[0];
      adc_tick <= tick_w[1];
    end
  end

  // dac samples queue in the fifo; producer sees its back-pressure
  vcst_stream_if #(.WIDTH(`VCST_PWM_BITS)) fin ();
  vcst_stream_if #(.WIDTH(`VCST_PWM_BITS)) fout ();
  assign fin.data  = dac_sample;
  // only a taken sample enters: a held offer while ready is low must not queue twice
  assign fin.valid = dac_valid && dac_ready;
  assign fout.ready = tick_w[0]; // R8
  vcst_fifo #(.WIDTH(`VCST_PWM_BITS), .DEPTH(`VCST_FIFO_DEPTH)) u_fifo (
    .clk  (clk),
    .rstn (rstn),
    .wr   (fin),
    .rd   (fout)
  );
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) dac_ready <= 1'b0;
    else       dac_ready <= fin.ready && !(dac_valid && dac_ready);
  end

  // duty held for a whole period; an empty fifo repeats the last sample
  vcst_duty_t duty_reg;
  vcst_duty_t pwm_cnt_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      duty_reg <= '0;
    end else if (tick_w[0] && fout.valid) begin
      duty_reg <= fout.data; // R8
    end
  end

  // 1024-step ramp advanced on crystal edges, restarted each dac tick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_cnt_reg <= '0;
    end else if (tick_w[0]) begin
      pwm_cnt_reg <= '0;
    end else if (xtal_rise && pwm_cnt_reg != '1) begin
      pwm_cnt_reg <= pwm_cnt_reg + 1'b1; // R1
    end
  end
  wire pwm_next = (pwm_cnt_reg < duty_reg); // R1 R7
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) pwm_out <= 1'b0;
    else       pwm_out <= pwm_next; // R7
  end

  // adc code from the converter pin, captured once per adc tick
  vcst_adc_t adc_s1_reg;
  vcst_adc_t adc_s2_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      adc_s1_reg <= '0;
      adc_s2_reg <= '0;
    end else begin
      adc_s1_reg <= adc_code;
      adc_s2_reg <= adc_s1_reg;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      adc_sample <= '0;
      adc_valid  <= 1'b0;
    end else begin
      adc_valid <= tick_w[1]; // R4
      if (tick_w[1]) adc_sample <= adc_s2_reg; // R4
    end
  end
endmodule : vcst_top
`default_nettype wire
